// File: uip_pkg.sv
`default_nettype none
package uip_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  ADDR_ENABLE  = 8'h00;
  localparam logic [7:0]  ADDR_IDENT   = 8'h04;
  localparam logic [7:0]  ADDR_CFG     = 8'h08;
  localparam logic [7:0]  ADDR_EVT     = 8'h0c;
  localparam logic [7:0]  ADDR_MASK    = 8'h10;

  // enable register bits
  localparam int          EN_RX        = 0;
  localparam int          EN_TX        = 1;
  localparam int          EN_LSR       = 2;
  localparam int          EN_PAUSE     = 5;
  localparam int          EN_RTS       = 6;
  localparam int          EN_CTS       = 7;
  localparam logic [7:0]  EN_ACTIVE    = 8'hef;
  localparam logic [7:0]  ENABLE_RST   = 8'h00;

  // identification codes in bits 5:0
  localparam logic [5:0]  ID_NONE      = 6'h01;
  localparam logic [5:0]  ID_LSR       = 6'h06;
  localparam logic [5:0]  ID_TMO       = 6'h0c;
  localparam logic [5:0]  ID_RX        = 6'h04;
  localparam logic [5:0]  ID_TX        = 6'h02;
  localparam logic [5:0]  ID_PAUSE     = 6'h10;
  localparam logic [5:0]  ID_FLOW      = 6'h20;
  localparam logic [7:0]  IDENT_RST    = 8'h01;

  // configuration register fields
  localparam int          LVL_W        = 7;
  localparam int          CFG_FIFO_EN  = 0;
  localparam int          CFG_RXTRIG   = 8;
  localparam int          CFG_TXTRIG   = 16;
  localparam logic [31:0] CFG_RST      = 32'h0000_0000;

  // event status / mask bits
  localparam int          EV_W         = 6;
  localparam int          EV_LSR       = 0;
  localparam int          EV_TMO       = 1;
  localparam int          EV_RX        = 2;
  localparam int          EV_TX        = 3;
  localparam int          EV_PAUSE     = 4;
  localparam int          EV_FLOW      = 5;
  localparam logic [5:0]  EVT_RST      = 6'h00;

  // conditions from the receiver, transmitter and flow control
  typedef struct packed {
    logic             overrunSet;
    logic             errInFifo;
    logic             staleSet;
    logic             rxDataAvail;
    logic             txHoldEmpty;
    logic             xoffSeen;
    logic             xonSeen;
    logic             specialSeen;
    logic [LVL_W-1:0] rxFill;
    logic [LVL_W-1:0] txFill;
  } uip_src_t;

  // one-cycle access strobes from the data path
  typedef struct packed {
    logic rhrRead;
    logic lsrRead;
    logic thrWrite;
  } uip_acc_t;
endpackage : uip_pkg
`default_nettype wire

// File: uip_ctrl.sv
// What this block does
// - six interrupt types each have an enable bit and intOut rises only for enabled pending ones.
// - with enable bits 0-3 and 5-7 all clear no interrupt reaches intOut; evtIrq still rises for masked-in events except receive data, which needs enable bit 0.
// - a pending interrupt clears ident bit 0 and puts its type code in ident bits 5:0.
// - line status is top priority, error-in-fifo clears when erroneous data is gone, overrun on line status read.
// - receive time-out at level 2 is cleared by a receive holding read.
// - receive data at level 2 follows data-ready, or fill above trigger with fifo on.
// - transmit at level 3 with fifo off follows holding-empty, cleared by ident read or holding write.
// - with fifo on the transmit interrupt rises when the tx fifo fill drops below its trigger level.
// - a pause from an xoff clears on xon, a pause from a special character on line status read.
// - level 6 rises when rts or cts goes from low to high and clears on ident read.
// - after reset the ident register reads bit 0 set and all else clear.
//
// The APB interface to the registers and the register addresses were decided locally.
`default_nettype none
module uip_ctrl
(
  input  wire  logic                       clk_sys,
  input  wire  logic                       rstn,
  input  wire  logic                       psel,
  input  wire  logic                       penable,
  input  wire  logic                       pwrite,
  input  wire  logic [uip_pkg::ADDR_W-1:0] paddr,
  input  wire  logic [31:0]                pwdata,
  output var   logic [31:0]                prdata,
  output var   logic                       pready,
  output var   logic                       pslverr,
  input  wire  uip_pkg::uip_src_t          src,
  input  wire  uip_pkg::uip_acc_t          acc,
  input  wire  logic                       ctsPinN,
  input  wire  logic                       rtsPinN,
  output var   logic                       intOut,
  output var   logic                       evtIrq
);
  import uip_pkg::*;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [7:0]  enable_reg;
  logic [7:0]  ident_reg;
  logic [7:0]  ident_next;
  logic [31:0] cfg_reg;
  logic [5:0]  evt_reg;
  logic [5:0]  mask_reg;
  logic        setupPh;
  logic        accessPh;
  logic        wrAcc;
  logic        rdAcc;
  logic        mapped;

  // answer is registered in setup, so every access takes one wait-free cycle
  assign setupPh  = psel && !penable;
  assign accessPh = psel && penable && pready;
  assign wrAcc    = accessPh && pwrite;
  assign rdAcc    = accessPh && !pwrite;

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == ADDR_ENABLE) || (a == ADDR_IDENT) || (a == ADDR_CFG)
            || (a == ADDR_EVT) || (a == ADDR_MASK);
  endfunction : isMapped

  assign mapped = isMapped(paddr);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setupPh;
      pslverr <= setupPh && !mapped;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      prdata <= 32'h0000_0000;
    else if (setupPh && !pwrite)
    begin
      case (paddr)
        ADDR_ENABLE: prdata <= {24'h00_0000, enable_reg};
        ADDR_IDENT:  prdata <= {24'h00_0000, ident_reg};
        ADDR_CFG:    prdata <= cfg_reg;
        ADDR_EVT:    prdata <= {26'h000_0000, evt_reg};
        ADDR_MASK:   prdata <= {26'h000_0000, mask_reg};
        default:     prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      enable_reg <= ENABLE_RST;
      cfg_reg    <= CFG_RST;
      mask_reg   <= EVT_RST;
    end
    else if (wrAcc)
    begin
      if (paddr == ADDR_ENABLE)
        enable_reg <= pwdata[7:0];
      if (paddr == ADDR_CFG)
        cfg_reg <= pwdata;
      if (paddr == ADDR_MASK)
        mask_reg <= pwdata[5:0];
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] ctsSync;
  logic [2:0] rtsSync;
  logic       ctsStable;
  logic       rtsStable;
  logic       ctsRise;
  logic       rtsRise;

  // a change counts only once stages two and three agree
  assign ctsRise = ctsSync[1] && ctsSync[2] && !ctsStable;
  assign rtsRise = rtsSync[1] && rtsSync[2] && !rtsStable;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ctsSync   <= 3'h7;
      rtsSync   <= 3'h7;
      ctsStable <= 1'b1;
      rtsStable <= 1'b1;
    end
    else
    begin
      ctsSync <= {ctsSync[1:0], ctsPinN};
      rtsSync <= {rtsSync[1:0], rtsPinN};
      if (ctsSync[1] == ctsSync[2])
        ctsStable <= ctsSync[2];
      if (rtsSync[1] == rtsSync[2])
        rtsStable <= rtsSync[2];
    end
  end

  // ----------------------------------------------------------------
  // source flags
  // ----------------------------------------------------------------
  logic             fifoEn;
  logic [LVL_W-1:0] rxTrig;
  logic [LVL_W-1:0] txTrig;
  logic             identRd;
  logic             overrunFlag;
  logic             tmoFlag;
  logic             txFlag;
  logic             txCond;
  logic             txCondQ;
  logic             pauseFlag;
  logic             pauseBySpecial;
  logic             rtsFlag;
  logic             ctsFlag;

  assign fifoEn  = cfg_reg[CFG_FIFO_EN];
  assign rxTrig  = cfg_reg[CFG_RXTRIG +: LVL_W];
  assign txTrig  = cfg_reg[CFG_TXTRIG +: LVL_W];
  assign identRd = rdAcc && (paddr == ADDR_IDENT);
  // tx condition is sampled on its rising edge so an ident read can retire it
  assign txCond  = fifoEn ? (src.txFill < txTrig) : src.txHoldEmpty;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      overrunFlag <= 1'b0;
    else if (src.overrunSet)
      overrunFlag <= 1'b1;
    else if (acc.lsrRead)
      overrunFlag <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      tmoFlag <= 1'b0;
    else if (src.staleSet)
      tmoFlag <= 1'b1;
    else if (acc.rhrRead)
      tmoFlag <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      txCondQ <= 1'b0;
      txFlag  <= 1'b0;
    end
    else
    begin
      txCondQ <= txCond;
      // retire by the code the host was shown, not a later one
      if (txCond && !txCondQ)
        txFlag <= 1'b1;
      else if (acc.thrWrite || (identRd && prdata[5:0] == ID_TX))
        txFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pauseFlag      <= 1'b0;
      pauseBySpecial <= 1'b0;
    end
    else if (src.xoffSeen || src.specialSeen)
    begin
      pauseFlag      <= 1'b1;
      pauseBySpecial <= src.specialSeen && !src.xoffSeen;
    end
    else if (pauseBySpecial ? acc.lsrRead : src.xonSeen)
      pauseFlag <= 1'b0;
  end

  // an ident read retires only the source it reported
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rtsFlag <= 1'b0;
      ctsFlag <= 1'b0;
    end
    else
    begin
      if (rtsRise)
        rtsFlag <= 1'b1;
      else if (identRd && prdata[5:0] == ID_FLOW)
        rtsFlag <= 1'b0;
      if (ctsRise)
        ctsFlag <= 1'b1;
      else if (identRd && prdata[5:0] == ID_FLOW)
        ctsFlag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // priority encoder
  // ----------------------------------------------------------------
  logic lsrPend;
  logic tmoPend;
  logic rxPend;
  logic txPend;
  logic pausePend;
  logic flowPend;
  logic anyPend;

  assign lsrPend   = enable_reg[EN_LSR] && (overrunFlag || src.errInFifo);
  assign tmoPend   = enable_reg[EN_RX] && tmoFlag;
  assign rxPend    = enable_reg[EN_RX]
                  && (fifoEn ? (src.rxFill > rxTrig) : src.rxDataAvail);
  assign txPend    = enable_reg[EN_TX] && txFlag;
  assign pausePend = enable_reg[EN_PAUSE] && pauseFlag;
  assign flowPend  = (enable_reg[EN_RTS] && rtsFlag)
                  || (enable_reg[EN_CTS] && ctsFlag);
  assign anyPend   = lsrPend || tmoPend || rxPend || txPend
                  || pausePend || flowPend;

  always_comb
  begin
    ident_next = {2'b00, ID_NONE};
    if (lsrPend)
      ident_next = {2'b00, ID_LSR};
    else if (tmoPend)
      ident_next = {2'b00, ID_TMO};
    else if (rxPend)
      ident_next = {2'b00, ID_RX};
    else if (txPend)
      ident_next = {2'b00, ID_TX};
    else if (pausePend)
      ident_next = {2'b00, ID_PAUSE};
    else if (flowPend)
      ident_next = {2'b00, ID_FLOW};
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ident_reg <= IDENT_RST;
      intOut    <= 1'b0;
    end
    else
    begin
      ident_reg <= ident_next;
      intOut    <= anyPend;
    end
  end

  // ----------------------------------------------------------------
  // event status, mask and summary interrupt
  // ----------------------------------------------------------------
  logic [5:0] evtSet;
  logic [5:0] evtKeep;
  logic       evtRd;
  logic       rxQ;
  logic       lsrQ;

  assign evtRd = rdAcc && (paddr == ADDR_EVT);
  // a read clears only what it reported; events after the setup edge survive
  assign evtKeep = evtRd ? (evt_reg & ~prdata[5:0]) : evt_reg;

  always_comb
  begin
    evtSet           = 6'h00;
    evtSet[EV_LSR]   = src.overrunSet || (src.errInFifo && !lsrQ);
    evtSet[EV_TMO]   = src.staleSet;
    evtSet[EV_RX]    = rxPend && !rxQ;
    evtSet[EV_TX]    = txCond && !txCondQ;
    evtSet[EV_PAUSE] = src.xoffSeen || src.specialSeen;
    evtSet[EV_FLOW]  = rtsRise || ctsRise;
  end

  // set wins over a clearing read in the same cycle
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      evt_reg <= EVT_RST;
      evtIrq  <= 1'b0;
      rxQ     <= 1'b0;
      lsrQ    <= 1'b0;
    end
    else
    begin
      evt_reg <= evtKeep | evtSet;
      evtIrq  <= |((evtKeep | evtSet) & mask_reg);
      rxQ     <= rxPend;
      lsrQ    <= src.errInFifo;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence sIdentRdTx;
    identRd && prdata[5:0] == ID_TX;
  endsequence

  sequence sNoTxSet;
    !(txCond && !txCondQ);
  endsequence

  a_int_follows: assert property (@(posedge clk_sys) disable iff (!rstn)
    anyPend |=> intOut)
    else $error("interrupt output missed a pending source");

  a_all_off: assert property (@(posedge clk_sys) disable iff (!rstn)
    ((enable_reg & EN_ACTIVE) == 8'h00) [*2] |-> !intOut)
    else $error("interrupt signalled with every enable clear");

  a_ident_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    anyPend |=> !ident_reg[0] && ident_reg[5:0] != ID_NONE)
    else $error("ident does not show a pending interrupt");

  a_lsr_top: assert property (@(posedge clk_sys) disable iff (!rstn)
    lsrPend |=> ident_reg[5:0] == ID_LSR)
    else $error("line status not reported first");

  a_overrun_clr: assert property (@(posedge clk_sys) disable iff (!rstn)
    acc.lsrRead && !src.overrunSet |=> !overrunFlag)
    else $error("overrun survived a line status read");

  a_tmo_clr: assert property (@(posedge clk_sys) disable iff (!rstn)
    acc.rhrRead && !src.staleSet |=> !tmoFlag)
    else $error("time-out survived a holding read");

  a_tmo_over_rx: assert property (@(posedge clk_sys) disable iff (!rstn)
    !lsrPend && tmoPend && rxPend |=> ident_reg[5:0] == ID_TMO)
    else $error("time-out lost priority to receive data");

  a_rx_fifo: assert property (@(posedge clk_sys) disable iff (!rstn)
    enable_reg[EN_RX] && fifoEn && src.rxFill > rxTrig && !lsrPend && !tmoFlag
    |=> ident_reg[5:0] == ID_RX)
    else $error("fifo above trigger not reported");

  a_tx_ident_clr: assert property (@(posedge clk_sys) disable iff (!rstn)
    sIdentRdTx ##0 sNoTxSet |=> !txFlag)
    else $error("ident read did not retire transmit source");

  a_tx_thr_clr: assert property (@(posedge clk_sys) disable iff (!rstn)
    acc.thrWrite ##0 sNoTxSet |=> !txFlag)
    else $error("holding write did not retire transmit source");

  a_pause_resume: assert property (@(posedge clk_sys) disable iff (!rstn)
    pauseFlag && !pauseBySpecial && src.xonSeen && !src.xoffSeen
    && !src.specialSeen |=> !pauseFlag)
    else $error("xon did not clear pause");

  a_flow_rise: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(ctsStable) |-> ctsFlag)
    else $error("cts low to high not caught");

  a_rts_rise: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(rtsStable) |-> rtsFlag)
    else $error("rts low to high not caught");

  a_reset_ident: assert property (@(posedge clk_sys)
    $rose(rstn) |-> ident_reg == IDENT_RST)
    else $error("ident not at reset value");
endmodule : uip_ctrl
`default_nettype wire

// File: uip_dpath_model.sv
`default_nettype none
module uip_dpath_model
(
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  input  wire logic [4:0]                 evtReq,
  input  wire logic [2:0]                 accReq,
  input  wire logic                       rxPush,
  input  wire logic                       errLvl,
  input  wire logic                       txEmpty,
  input  wire logic [uip_pkg::LVL_W-1:0]  rxFillIn,
  input  wire logic [uip_pkg::LVL_W-1:0]  txFillIn,
  output var  uip_pkg::uip_src_t          src,
  output var  uip_pkg::uip_acc_t          acc
);
  timeunit 1ns;
  timeprecision 100ps;
  import uip_pkg::*;

  logic dataReady;

  // ----------------------------------------------------------------
  // receiver data-ready
  // ----------------------------------------------------------------
  // a holding read empties the single-character receiver
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      dataReady <= 1'b0;
    else if (rxPush)
      dataReady <= 1'b1;
    else if (accReq[2])
      dataReady <= 1'b0;

  // ----------------------------------------------------------------
  // registered conditions and access strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      src <= '0;
      acc <= '0;
    end
    else
    begin
      src.overrunSet  <= evtReq[0];
      src.staleSet    <= evtReq[1];
      src.xoffSeen    <= evtReq[2];
      src.xonSeen     <= evtReq[3];
      src.specialSeen <= evtReq[4];
      src.errInFifo   <= errLvl;
      src.rxDataAvail <= dataReady;
      src.txHoldEmpty <= txEmpty;
      src.rxFill      <= rxFillIn;
      src.txFill      <= txFillIn;
      acc             <= accReq;
    end
endmodule : uip_dpath_model
`default_nettype wire

// File: uart_interrupt_priority_tb.sv
`default_nettype none
module uart_interrupt_priority_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import uip_pkg::*;

  logic             clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd, r, t, v;
  logic [4:0]       evtReq;
  logic [2:0]       accReq;
  logic             rxPush, errLvl, txEmpty, ctsPinN, rtsPinN, intOut, evtIrq, er;
  logic [LVL_W-1:0] rxFillIn, txFillIn;
  uip_src_t         src;
  uip_acc_t         acc;
  int               seed, failCount, checks;

  uip_ctrl uip_ctrl_i (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src(src), .acc(acc), .ctsPinN(ctsPinN), .rtsPinN(rtsPinN),
    .intOut(intOut), .evtIrq(evtIrq));
  uip_dpath_model uip_dpath_model_i (.clk_sys(clk_sys), .rstn(rstn), .evtReq(evtReq),
    .accReq(accReq), .rxPush(rxPush), .errLvl(errLvl), .txEmpty(txEmpty),
    .rxFillIn(rxFillIn), .txFillIn(txFillIn), .src(src), .acc(acc));

  always #12.5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // pending event bits to the identification word, by priority
  function automatic logic [31:0] expId(input logic [5:0] p);
    logic [5:0] c;
    c = p[EV_LSR] ? ID_LSR : p[EV_TMO] ? ID_TMO : p[EV_RX] ? ID_RX :
        p[EV_TX] ? ID_TX : p[EV_PAUSE] ? ID_PAUSE : p[EV_FLOW] ? ID_FLOW : ID_NONE;
    return {26'h0, c};
  endfunction : expId

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1 && ++n < 50);
    if (n >= 50)
      failCount++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdChk

  // bit 5 of e is a receive push, bits 4:0 the data-path pulses
  task automatic kick(input logic [5:0] e, input logic [2:0] c);
    @(posedge clk_sys);
    evtReq <= e[4:0];
    rxPush <= e[5];
    accReq <= c;
    @(posedge clk_sys);
    evtReq <= '0;
    rxPush <= 1'b0;
    accReq <= '0;
    wt(6);
  endtask : kick

  task automatic finishTest;
    $display("checks %0d fail_count %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finishTest

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    {clk_sys, rstn, psel, penable, pwrite, rxPush, errLvl, txEmpty} = '0;
    {paddr, pwdata, evtReq, accReq, rxFillIn, txFillIn} = '0;
    {ctsPinN, rtsPinN} = 2'b11;
    {seed, failCount, checks} = {32'h1822, 64'h0};
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    rdChk(ADDR_IDENT, expId(6'h00));
    for (int i = 0; i < 4; i++)
    begin
      v = $random(seed);
      apb(1'b1, ADDR_ENABLE, v);
      rdChk(ADDR_ENABLE, {24'h0, v[7:0]});
    end
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, ADDR_ENABLE, {24'h0, EN_ACTIVE});
    apb(1'b1, ADDR_MASK, 32'h2);
    kick(6'h01, 3'h0);
    chk({31'h0, evtIrq}, 32'h0);
    rdChk(ADDR_IDENT, expId(6'h01));
    kick(6'h02, 3'h0);
    chk({31'h0, evtIrq}, 32'h1);
    rdChk(ADDR_EVT, 32'h3);
    wt(2);
    chk({31'h0, evtIrq}, 32'h0);
    kick(6'h00, 3'h2);
    rdChk(ADDR_IDENT, expId(6'h02));
    apb(1'b1, ADDR_ENABLE, 32'h10);
    wt(3);
    chk({31'h0, intOut}, 32'h0);
    apb(1'b1, ADDR_ENABLE, 32'h01);
    wt(3);
    chk({31'h0, intOut}, 32'h1);
    kick(6'h00, 3'h4);
    rdChk(ADDR_IDENT, expId(6'h00));
    apb(1'b1, ADDR_ENABLE, {24'h0, EN_ACTIVE});
    errLvl  <= 1'b1;
    txEmpty <= 1'b1;
    kick(6'h20, 3'h0);
    rdChk(ADDR_IDENT, expId(6'h0d));
    errLvl <= 1'b0;
    wt(6);
    rdChk(ADDR_IDENT, expId(6'h0c));
    kick(6'h00, 3'h4);
    rdChk(ADDR_IDENT, expId(6'h08));
    kick(6'h00, 3'h1);
    rdChk(ADDR_IDENT, expId(6'h00));
    txEmpty <= 1'b0;
    wt(4);
    txEmpty <= 1'b1;
    wt(6);
    rdChk(ADDR_IDENT, expId(6'h08));
    rdChk(ADDR_IDENT, expId(6'h00));
    for (int i = 0; i < 3; i++)
    begin
      r = 32'h1 + ($random(seed) & 32'h3f);
      t = 32'h1 + ($random(seed) & 32'h3f);
      txFillIn <= 7'h7f;
      apb(1'b1, ADDR_CFG, {9'h0, t[6:0], 1'b0, r[6:0], 7'h0, 1'b1});
      rxFillIn <= r[6:0];
      wt(6);
      rdChk(ADDR_IDENT, expId(6'h00));
      rxFillIn <= r[6:0] + 7'h1;
      wt(6);
      rdChk(ADDR_IDENT, expId(6'h04));
      rxFillIn <= '0;
      txFillIn <= t[6:0] - 7'h1;
      wt(6);
      rdChk(ADDR_IDENT, expId(6'h08));
      rdChk(ADDR_IDENT, expId(6'h00));
    end
    kick(6'h04, 3'h0);
    rdChk(ADDR_IDENT, expId(6'h10));
    kick(6'h08, 3'h0);
    rdChk(ADDR_IDENT, expId(6'h00));
    kick(6'h10, 3'h0);
    rdChk(ADDR_IDENT, expId(6'h10));
    kick(6'h00, 3'h2);
    rdChk(ADDR_IDENT, expId(6'h00));
    for (int k = 0; k < 2; k++)
    begin
      {ctsPinN, rtsPinN} <= k ? 2'b01 : 2'b10;
      wt(6);
      {ctsPinN, rtsPinN} <= 2'b11;
      wt(8);
      chk({31'h0, intOut}, 32'h1);
      rdChk(ADDR_IDENT, expId(6'h20));
      rdChk(ADDR_IDENT, expId(6'h00));
    end
    // mid-run reset: transmit source latches while every enable is clear
    rstn <= 1'b0;
    wt(3);
    rstn <= 1'b1;
    rdChk(ADDR_ENABLE, 32'h0);
    rdChk(ADDR_IDENT, expId(6'h00));
    apb(1'b1, ADDR_ENABLE, 32'h02);
    wt(3);
    rdChk(ADDR_IDENT, expId(6'h08));
    finishTest();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failCount++;
    finishTest();
  end
endmodule : uart_interrupt_priority_tb
`default_nettype wire
